// ---- logic/opdec_pkg.sv ----
// opcode constants, decoded classes and the decode result record
package opdec_pkg;
	localparam logic [7:0] OP_SEG_LOAD = 8'h8E; // 10001110
	localparam logic [7:0] OP_SEG_STORE = 8'h8C; // 10001100
	localparam logic [7:0] OP_TABLE_TRANSLATE_OP_BYTE = 8'hD7; // 11010111
	localparam logic [7:0] OP_EA_LOAD = 8'h8D; // 10001101
	localparam logic [7:0] OP_PTR_DS = 8'hC5; // 11000101
	localparam logic [7:0] OP_PTR_ES = 8'hC4; // 11000100
	localparam logic [7:0] OP_FLAGS_TO_AH = 8'h9F; // 10011111
	localparam logic [7:0] OP_AH_TO_FLAGS = 8'h9E; // 10011110
	localparam logic [7:0] OP_ASCII_ADJ = 8'h37; // 00110111
	localparam logic [7:0] OP_DEC_ADJ = 8'h27; // 00100111
	// six-bit prefixes of forms that carry d and w in the low bits
	localparam logic [5:0] PFX_ADC_RM = 6'h04; // 000100dw
	localparam logic [5:0] PFX_SUB_RM = 6'h0A; // 001010dw
	// seven-bit prefix of a form that carries w in the low bit, then the six-bit immediate group that carries s and w
	localparam logic [6:0] PFX_SBB_ACC = 7'h0E; // 0001110w
	localparam logic [5:0] PFX_IMM_GRP = 6'h20; // 100000sw
	localparam logic [2:0] EXT_SBB = 3'h3; // middle field 011
	localparam int W_BIT = 0;
	localparam int D_BIT = 1;
	localparam int S_BIT = 1;
	localparam int REG_MSB = 5;
	localparam int REG_LSB = 3;
	localparam int SEG_ZERO_BIT = 5;
	localparam int OP_MSB = 7; // top bit of a first byte
	localparam int PFX6_LSB = 2; // low end of a six-bit prefix
	localparam int PFX7_LSB = 1; // low end of a seven-bit prefix
	localparam int MOD_MSB = 7;
	localparam int MOD_LSB = 6;
	localparam int RM_MSB = 2;
	localparam int RM_LSB = 0;
	localparam logic [1:0] IMM_ONE = 2'h1; // one immediate byte follows
	localparam logic [1:0] IMM_TWO = 2'h2; // two immediate bytes follow

	typedef enum logic [4:0] {
		CLS_NONE = 5'h00,
		CLS_SEG_LOAD = 5'h01,
		CLS_SEG_STORE = 5'h02,
		CLS_ADC_RM = 5'h03,
		CLS_SUB_RM = 5'h04,
		CLS_SBB_ACC_IMM = 5'h05,
		CLS_SBB_RM_IMM = 5'h06,
		CLS_TABLE_TABLE_TRANSLATE_OP = 5'h07,
		CLS_EA_LOAD = 5'h08,
		CLS_PTR_DS = 5'h09,
		CLS_PTR_ES = 5'h0A,
		CLS_FLAGS_TO_AH = 5'h0B,
		CLS_AH_TO_FLAGS = 5'h0C,
		CLS_ASCII_ADJ = 5'h0D,
		CLS_DEC_ADJ = 5'h0E,
		CLS_ILLEGAL = 5'h1F
	} op_class_t;

	typedef struct packed {
		op_class_t op_class;
		logic word_op; // 1 = 16-bit operand
		logic reg_is_dest; // 1 = register field is destination
		logic [1:0] imm_bytes; // immediate bytes still to consume
		logic [2:0] reg_field;
		logic [1:0] mod_field;
		logic [2:0] rm_field;
	} decode_t;
endpackage : opdec_pkg

// ---- logic/opcode_decoder.sv ----
// first-byte and operand-mode-byte decoder for transfer and arithmetic opcodes
`timescale 1ns/1ps

// Function
// RULE1: 8E with operand-mode byte bit5 clear moves word into segment register.
// RULE2: 8C with operand-mode byte stores segment register to register or memory.
// RULE3: 000100dw with operand-mode byte is add-with-carry; d,w from low bits.
// RULE4: 001010dw with operand-mode byte is subtract, result to either side.
// RULE5: 0001110w is borrow-subtract immediate from accumulator; 100000sw/011 from r/m.
// RULE6: single byte D7 is table translate into low accumulator byte.
// RULE7: 8D with operand-mode byte loads effective address into register.
// RULE8: C5 with operand-mode byte loads pointer into register and data segment.
// RULE9: C4 with operand-mode byte loads pointer into register and extra segment.
// RULE10: single byte 9F copies flags into accumulator high byte.
// RULE11: single byte 9E writes accumulator high byte into flags.
// RULE12: single byte 37 is unpacked decimal adjust after addition.
// RULE13: single byte 27 is packed decimal adjust after addition.
// RULE14: width bit zero means byte operand, one means word; sets immediate count.
// RULE15: direction bit set makes register field destination, clear makes it source.
module opcode_decoder (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	output logic byte_ready,
	output opdec_pkg::decode_t dec_out,
	output logic dec_valid,
	input wire logic dec_ready
);
	typedef enum logic [1:0] {
		ST_FIRST = 2'b00,
		ST_MODE = 2'b01,
		ST_HOLD = 2'b10
	} state_t;

	// ==========================================================
	// reset release
	// the pin reset is asserted at once but released through two flops,
	// so every register below leaves reset on the same clock edge
	logic rst_s1_reg;
	logic rst_s2_reg;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	wire rst_n_sync = rst_s2_reg;

	// ==========================================================
	// helpers
	// upper six bits of a first byte, the part ahead of d and w
	function automatic logic [5:0] prefix6(input logic [7:0] b);
		return b[opdec_pkg::OP_MSB:opdec_pkg::PFX6_LSB];
	endfunction : prefix6

	// upper seven bits of a first byte, the part ahead of w
	function automatic logic [6:0] prefix7(input logic [7:0] b);
		return b[opdec_pkg::OP_MSB:opdec_pkg::PFX7_LSB];
	endfunction : prefix7

	// addressing mode field of an operand-mode byte
	function automatic logic [1:0] mode_mod(input logic [7:0] m);
		return m[opdec_pkg::MOD_MSB:opdec_pkg::MOD_LSB];
	endfunction : mode_mod

	// register or extension field of an operand-mode byte
	function automatic logic [2:0] mode_reg(input logic [7:0] m);
		return m[opdec_pkg::REG_MSB:opdec_pkg::REG_LSB];
	endfunction : mode_reg

	// register-or-memory field of an operand-mode byte
	function automatic logic [2:0] mode_rm(input logic [7:0] m);
		return m[opdec_pkg::RM_MSB:opdec_pkg::RM_LSB];
	endfunction : mode_rm

	// immediate bytes for a width bit and sign-extend bit
	// a set sign bit squeezes a word immediate into one byte
	function automatic logic [1:0] imm_count(input logic w, input logic s);
		logic [1:0] n;
		n = opdec_pkg::IMM_ONE;
		if (w && !s) begin
			n = opdec_pkg::IMM_TWO;
		end
		return n;
	endfunction : imm_count

	// does this first byte need an operand-mode byte
	// a miss here would decode the mode byte as a new opcode
	function automatic logic needs_mode(input logic [7:0] b);
		logic r;
		r = 1'b0;
		case (b)
			opdec_pkg::OP_SEG_LOAD: r = 1'b1;
			opdec_pkg::OP_SEG_STORE: r = 1'b1;
			opdec_pkg::OP_EA_LOAD: r = 1'b1;
			opdec_pkg::OP_PTR_DS: r = 1'b1;
			opdec_pkg::OP_PTR_ES: r = 1'b1;
			default: begin
				if (prefix6(b) == opdec_pkg::PFX_ADC_RM) begin
					r = 1'b1;
				end
				if (prefix6(b) == opdec_pkg::PFX_SUB_RM) begin
					r = 1'b1;
				end
				if (prefix6(b) == opdec_pkg::PFX_IMM_GRP) begin
					r = 1'b1;
				end
			end
		endcase
		return r;
	endfunction : needs_mode

	// ==========================================================
	// state and captured bytes
	state_t state_reg;
	state_t state_next;
	logic [7:0] first_reg;
	opdec_pkg::decode_t dec_reg;
	opdec_pkg::decode_t dec_next;

	// handshake outputs straight from the state register
	// a held result blocks new bytes until the consumer takes it,
	// so no byte can overwrite a result nobody has seen yet
	assign byte_ready = (state_reg != ST_HOLD);
	assign dec_valid = (state_reg == ST_HOLD);
	// result leaves from flops, never from the decode functions
	assign dec_out = dec_reg;

	// a byte moves only on an edge where both sides agree
	wire take = byte_valid && byte_ready;

	// single-byte and first-byte decode
	// anything not listed falls out as illegal, never as a stale class
	function automatic opdec_pkg::decode_t decode_single(input logic [7:0] b);
		opdec_pkg::decode_t d;
		d = '0;
		d.op_class = opdec_pkg::CLS_ILLEGAL;
		case (b)
			opdec_pkg::OP_TABLE_TRANSLATE_OP_BYTE: begin
				// RULE6: table translate
				d.op_class = opdec_pkg::CLS_TABLE_TABLE_TRANSLATE_OP;
			end
			opdec_pkg::OP_FLAGS_TO_AH: begin
				// RULE10: flags to high
				d.op_class = opdec_pkg::CLS_FLAGS_TO_AH;
			end
			opdec_pkg::OP_AH_TO_FLAGS: begin
				// RULE11: high to flags
				d.op_class = opdec_pkg::CLS_AH_TO_FLAGS;
			end
			opdec_pkg::OP_ASCII_ADJ: begin
				// RULE12: ascii adjust
				d.op_class = opdec_pkg::CLS_ASCII_ADJ;
			end
			opdec_pkg::OP_DEC_ADJ: begin
				// RULE13: decimal adjust
				d.op_class = opdec_pkg::CLS_DEC_ADJ;
			end
			default: begin
				// RULE5: accumulator immediate form
				if (prefix7(b) == opdec_pkg::PFX_SBB_ACC) begin
					d.op_class = opdec_pkg::CLS_SBB_ACC_IMM;
					d.word_op = b[opdec_pkg::W_BIT];
					// RULE14: width sets immediates
					d.imm_bytes = imm_count(b[opdec_pkg::W_BIT], 1'b0);
				end
			end
		endcase
		return d;
	endfunction : decode_single

	// decode of first byte plus operand-mode byte
	// the mode fields are passed on even for an illegal pair,
	// so execution can report what it was handed
	function automatic opdec_pkg::decode_t decode_pair(input logic [7:0] f, input logic [7:0] m);
		opdec_pkg::decode_t d;
		d = '0;
		d.op_class = opdec_pkg::CLS_ILLEGAL;
		d.mod_field = mode_mod(m);
		d.reg_field = mode_reg(m);
		d.rm_field = mode_rm(m);
		// segment, pointer and address forms always move words
		d.word_op = 1'b1;
		case (f)
			opdec_pkg::OP_SEG_LOAD: begin
				// RULE1: segment load needs zero bit
				if (!m[opdec_pkg::SEG_ZERO_BIT]) begin
					d.op_class = opdec_pkg::CLS_SEG_LOAD;
					d.reg_is_dest = 1'b1;
				end
			end
			opdec_pkg::OP_SEG_STORE: begin
				// RULE2: segment store, register field is the source
				d.op_class = opdec_pkg::CLS_SEG_STORE;
			end
			opdec_pkg::OP_EA_LOAD: begin
				// RULE7: address not contents
				d.op_class = opdec_pkg::CLS_EA_LOAD;
				d.reg_is_dest = 1'b1;
			end
			opdec_pkg::OP_PTR_DS: begin
				// RULE8: pointer with data segment
				d.op_class = opdec_pkg::CLS_PTR_DS;
				d.reg_is_dest = 1'b1;
			end
			opdec_pkg::OP_PTR_ES: begin
				// RULE9: pointer with extra segment
				d.op_class = opdec_pkg::CLS_PTR_ES;
				d.reg_is_dest = 1'b1;
			end
			default: begin
				if (prefix6(f) == opdec_pkg::PFX_ADC_RM) begin
					// RULE3: add with carry form
					d.op_class = opdec_pkg::CLS_ADC_RM;
					// RULE14: width bit
					d.word_op = f[opdec_pkg::W_BIT];
					// RULE15: direction bit
					d.reg_is_dest = f[opdec_pkg::D_BIT];
				end else if (prefix6(f) == opdec_pkg::PFX_SUB_RM) begin
					// RULE4: subtract form
					d.op_class = opdec_pkg::CLS_SUB_RM;
					// RULE14: width bit
					d.word_op = f[opdec_pkg::W_BIT];
					// RULE15: direction bit
					d.reg_is_dest = f[opdec_pkg::D_BIT];
				end else if (prefix6(f) == opdec_pkg::PFX_IMM_GRP &&
					mode_reg(m) == opdec_pkg::EXT_SBB) begin
					// other extension codes of this group belong to other blocks
					// RULE5: register or memory immediate form
					d.op_class = opdec_pkg::CLS_SBB_RM_IMM;
					d.word_op = f[opdec_pkg::W_BIT];
					// RULE14: width sets immediates
					d.imm_bytes = imm_count(f[opdec_pkg::W_BIT], f[opdec_pkg::S_BIT]);
				end
			end
		endcase
		return d;
	endfunction : decode_pair

	// next state and result
	// first byte either finishes at once or waits for its mode byte;
	// the result is held until the consumer accepts it
	always_comb begin
		state_next = state_reg;
		dec_next = dec_reg;
		case (state_reg)
			ST_FIRST: begin
				if (take) begin
					if (needs_mode(byte_data)) begin
						state_next = ST_MODE;
					end else begin
						dec_next = decode_single(byte_data);
						state_next = ST_HOLD;
					end
				end
			end
			ST_MODE: begin
				if (take) begin
					dec_next = decode_pair(first_reg, byte_data);
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (dec_ready) begin
					state_next = ST_FIRST;
				end
			end
			default: state_next = ST_FIRST;
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg <= ST_FIRST;
		end else begin
			state_reg <= state_next;
		end
	end

	// result register
	always_ff @(posedge mclk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			dec_reg <= '0;
		end else begin
			dec_reg <= dec_next;
		end
	end

	// first byte capture
	always_ff @(posedge mclk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			first_reg <= 8'h00;
		end else if (take && state_reg == ST_FIRST) begin
			first_reg <= byte_data;
		end
	end
endmodule : opcode_decoder

// ---- verification/opcode_decoder_asserts.sv ----
// checker for decode results of the opcode decoder
`timescale 1ns/1ps
module opcode_decoder_asserts (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	input wire logic byte_ready,
	input wire opdec_pkg::decode_t dec_out,
	input wire logic dec_valid,
	input wire logic dec_ready
);
	// ==========
	// mode byte tracking
	logic pend_reg;
	logic [7:0] op_reg;
	logic [7:0] mb_reg;
	logic take;
	logic first;
	assign take = byte_valid && byte_ready;
	assign first = take && !pend_reg;
	// remember the first byte, the last byte, and whether a mode byte is due
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pend_reg <= 1'b0;
			op_reg <= 8'h00;
			mb_reg <= 8'h00;
		end else if (take) begin
			pend_reg <= first && (byte_data inside {8'h8E, 8'h8C, 8'h8D, 8'hC4, 8'hC5}
				|| byte_data[7:2] inside {6'h04, 6'h0A, 6'h20});
			op_reg <= first ? byte_data : op_reg;
			mb_reg <= byte_data;
		end
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_FIELDS: assert property (take && pend_reg |=> dec_out.op_class == opdec_pkg::CLS_ILLEGAL
		|| {dec_out.mod_field, dec_out.reg_field, dec_out.rm_field} == mb_reg) else $error("mode fields wrong");
	AST_SBB_IMM: assert property (take && pend_reg && op_reg[7:2] == 6'h20 && byte_data[5:3] == 3'h3 |=>
		dec_out.op_class == opdec_pkg::CLS_SBB_RM_IMM && dec_out.imm_bytes == (op_reg[1:0] == 2'h1 ? 2'h2 : 2'h1))
		else $error("borrow immediate wrong");
	AST_WIDTH: assert property (take && pend_reg && op_reg[7:2] inside {6'h04, 6'h0A} |=>
		dec_out.word_op == op_reg[0] && dec_out.reg_is_dest == op_reg[1]) else $error("width or direction wrong");
	AST_TABLE_TRANSLATE_OP: assert property (first && byte_data == 8'hD7 |=> dec_out.op_class == opdec_pkg::CLS_TABLE_TABLE_TRANSLATE_OP)
		else $error("translate class wrong");
	AST_TO_AH: assert property (first && byte_data == 8'h9F |=> dec_out.op_class == opdec_pkg::CLS_FLAGS_TO_AH)
		else $error("flags copy class wrong");
	AST_TO_FL: assert property (first && byte_data == 8'h9E |=> dec_out.op_class == opdec_pkg::CLS_AH_TO_FLAGS)
		else $error("flags write class wrong");
	AST_ASCII: assert property (first && byte_data == 8'h37 |=> dec_out.op_class == opdec_pkg::CLS_ASCII_ADJ)
		else $error("ascii adjust class wrong");
	AST_DEC: assert property (first && byte_data == 8'h27 |=> dec_out.op_class == opdec_pkg::CLS_DEC_ADJ)
		else $error("decimal adjust class wrong");
	AST_PTR: assert property (take && pend_reg && op_reg == 8'hC5 |=> dec_out.op_class == opdec_pkg::CLS_PTR_DS)
		else $error("pointer load class wrong");
endmodule : opcode_decoder_asserts
bind opcode_decoder opcode_decoder_asserts chk (.mclk(mclk), .rst_b(rst_b), .byte_data(byte_data),
	.byte_valid(byte_valid), .byte_ready(byte_ready), .dec_out(dec_out), .dec_valid(dec_valid), .dec_ready(dec_ready));

// ---- verification/fetch_queue_model.sv ----
// fetch queue model offering opcode bytes
`timescale 1ns/1ps
module fetch_queue_model (
	input wire logic mclk,
	input wire logic byte_ready,
	output logic [7:0] byte_data,
	output logic byte_valid
);
	initial begin
		byte_data = 8'h00;
		byte_valid = 1'b0;
	end
	// offer a byte and hold it until an edge takes it
	// ready is looked at before the edge, where it is settled
	task automatic send(input logic [7:0] b);
		logic got;
		byte_data = b;
		if (byte_valid !== 1'b1) byte_valid = 1'b1;
		got = (byte_ready === 1'b1);
		@(posedge mclk);
		while (!got) begin
			@(negedge mclk);
			got = (byte_ready === 1'b1);
			@(posedge mclk);
		end
		@(negedge mclk);
	endtask : send
	// released lines show the inverse so a stale byte cannot pass
	task automatic stop();
		byte_valid = 1'b0;
		byte_data = ~byte_data;
	endtask : stop
endmodule : fetch_queue_model

// ---- verification/cpu_opcode_decoder_xfer_arith_tb.sv ----
// self-checking testbench for the opcode decoder
`timescale 1ns/1ps
module cpu_opcode_decoder_xfer_arith_tb;
	localparam logic [16:0] MC = 17'h1F000; // class only
	localparam logic [16:0] MK = 17'h1FB00; // class, width, immediate count
	localparam logic [16:0] MF = 17'h1FFFF;
	logic mclk, rst_b, dec_ready, byte_ready, dec_valid, byte_valid;
	logic [7:0] byte_data;
	opdec_pkg::decode_t dec_out;
	int n_errors, check_count;
	opcode_decoder uut (.mclk(mclk), .rst_b(rst_b), .byte_data(byte_data), .byte_valid(byte_valid),
		.byte_ready(byte_ready), .dec_out(dec_out), .dec_valid(dec_valid), .dec_ready(dec_ready));
	fetch_queue_model fq (.mclk(mclk), .byte_ready(byte_ready), .byte_data(byte_data), .byte_valid(byte_valid));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	function automatic opdec_pkg::decode_t mk(opdec_pkg::op_class_t c, logic w, logic d, logic [1:0] n, logic [7:0] m);
		return '{c, w, d, n, m[5:3], m[7:6], m[2:0]};
	endfunction : mk
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// offer one instruction, compare the masked result, then accept it
	task automatic run(input logic [7:0] b1, b2, input logic two, input opdec_pkg::decode_t e, input logic [16:0] m);
		fq.send(b1);
		if (two) fq.send(b2);
		fq.stop();
		for (int i = 0; i < 4 && dec_valid !== 1'b1; i++) @(negedge mclk);
		check_count++;
		if ((dec_out & m) !== (e & m) || dec_valid !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: opcode %h gave %h", $time, b1, dec_out);
		end
		// result must stand and block bytes while not accepted
		@(negedge mclk);
		check_count++;
		if (dec_valid !== 1'b1 || byte_ready !== 1'b0 || (dec_out & m) !== (e & m)) begin
			n_errors++;
			$display("mismatch at %0t: held result of %h not standing", $time, b1);
		end
		dec_ready = 1'b1;
		@(negedge mclk);
		dec_ready = 1'b0;
		check_count++;
		if (dec_valid !== 1'b0 || byte_ready !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: result of %h not released", $time, b1);
		end
	endtask : run
	task automatic scen_single();
		run(8'hD7, '0, 1'b0, mk(opdec_pkg::CLS_TABLE_TABLE_TRANSLATE_OP, '0, '0, '0, '0), MC);
		run(8'h9F, '0, 1'b0, mk(opdec_pkg::CLS_FLAGS_TO_AH, '0, '0, '0, '0), MC);
		run(8'h9E, '0, 1'b0, mk(opdec_pkg::CLS_AH_TO_FLAGS, '0, '0, '0, '0), MC);
		run(8'h37, '0, 1'b0, mk(opdec_pkg::CLS_ASCII_ADJ, '0, '0, '0, '0), MC);
		run(8'h27, '0, 1'b0, mk(opdec_pkg::CLS_DEC_ADJ, '0, '0, '0, '0), MC);
	endtask : scen_single
	task automatic scen_seg();
		run(8'h8E, 8'h5A, 1'b1, mk(opdec_pkg::CLS_SEG_LOAD, 1'b1, 1'b1, '0, 8'h5A), MF);
		run(8'h8E, 8'h26, 1'b1, mk(opdec_pkg::CLS_ILLEGAL, '0, '0, '0, '0), MC);
		run(8'h8C, 8'hC8, 1'b1, mk(opdec_pkg::CLS_SEG_STORE, 1'b1, 1'b0, '0, 8'hC8), MF);
		run(8'h8D, 8'h1F, 1'b1, mk(opdec_pkg::CLS_EA_LOAD, 1'b1, 1'b1, '0, 8'h1F), MF);
		run(8'hC5, 8'h03, 1'b1, mk(opdec_pkg::CLS_PTR_DS, 1'b1, 1'b1, '0, 8'h03), MF);
		run(8'hC4, 8'hF0, 1'b1, mk(opdec_pkg::CLS_PTR_ES, 1'b1, 1'b1, '0, 8'hF0), MF);
	endtask : scen_seg
	task automatic scen_arith();
		for (int i = 0; i < 4; i++) begin
			run(8'h10 | 8'(i), 8'h5A, 1'b1, mk(opdec_pkg::CLS_ADC_RM, i[0], i[1], '0, 8'h5A), MF);
			run(8'h28 | 8'(i), 8'hA7, 1'b1, mk(opdec_pkg::CLS_SUB_RM, i[0], i[1], '0, 8'hA7), MF);
		end
	endtask : scen_arith
	task automatic scen_borrow();
		for (int i = 0; i < 2; i++)
			run(8'h1C | 8'(i), '0, 1'b0, mk(opdec_pkg::CLS_SBB_ACC_IMM, i[0], '0, 2'(i + 1), '0), MK);
		for (int i = 0; i < 4; i++)
			run(8'h80 | 8'(i), 8'hD9, 1'b1, mk(opdec_pkg::CLS_SBB_RM_IMM, i[0], 1'b0, (i == 1) ? 2'h2 : 2'h1, 8'hD9), MF);
		run(8'h81, 8'hD1, 1'b1, mk(opdec_pkg::CLS_ILLEGAL, '0, '0, '0, '0), MC);
	endtask : scen_borrow
	initial begin
		n_errors = 0;
		check_count = 0;
		rst_b = 1'b0;
		dec_ready = 1'b0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		repeat (3) @(negedge mclk);
		scen_single();
		scen_seg();
		scen_arith();
		scen_borrow();
		complete_run();
	end
	// watchdog against a hang
	initial begin
		#5000;
		n_errors++;
		complete_run();
	end
endmodule : cpu_opcode_decoder_xfer_arith_tb
